// ### rtl/cfb_pkg.sv
// Package for the CAN filter configuration bank: offsets, fields and reset values.
// Assumes a byte-wide register port behind a page select register.
package cfb_pkg;
  // Page window geometry and page numbers.
  localparam int unsigned         PAGE_BYTES      = 16;
  localparam logic [3:0]          PAGE_OFFS_W     = 4'h4;
  localparam logic [2:0]          FILTER_PAGE     = 3'h6;
  // Register offsets: page select outside the window, paged registers inside it.
  localparam logic [4:0]          PAGE_SEL_ADDR   = 5'h0F;
  localparam logic [4:0]          BANK45_ADDR     = 5'h10;
  localparam logic [4:0]          MODE03_ADDR     = 5'h11;
  // Reset values.
  localparam logic [7:0]          BANK45_RESET    = 8'h00;
  localparam logic [7:0]          MODE03_RESET    = 8'h00;
  localparam logic [2:0]          PAGE_SEL_RESET  = 3'h0;
  // Field positions of the bank 4/5 register.
  localparam int unsigned         B5_SCALE_HI     = 6;
  localparam int unsigned         B5_SCALE_LO     = 5;
  localparam int unsigned         B5_ACTIVE_BIT   = 4;
  localparam int unsigned         B4_SCALE_HI     = 2;
  localparam int unsigned         B4_SCALE_LO     = 1;
  localparam int unsigned         B4_ACTIVE_BIT   = 0;
  // Writable bits of the bank 4/5 register; bits 7 and 3 stay zero.
  localparam logic [7:0]          BANK45_WMASK    = 8'h77;
  // Bank count.
  localparam int unsigned         NUM_BANKS       = 6;
endpackage

// ### rtl/cfb_bank_gate.sv
// Per-bank acceptance gate: a bank hit only counts while the bank is active.
// Assumes hit inputs come from comparator logic on the same clock.
`timescale 1ns/10ps
module cfb_bank_gate #(
  parameter int unsigned NB = 6
) (
  // Bank state.
  input  wire logic [NB-1:0] active_i,
  input  wire logic [NB-1:0] hit_i,
  // Gated result.
  output logic      [NB-1:0] accept_o
);
  // Inactive banks never accept, whatever their values hold.
  genvar g;
  for (g = 0; g < NB; g++) begin : g_bank
    assign accept_o[g] = hit_i[g] & active_i[g];
  end
endmodule

// ### rtl/cfb_config.sv
// CAN filter configuration: page select, bank 4/5 setup and bank 0-3 mode registers.
// Assumes a single-cycle byte register port on mclk_i; hits come from same-clock logic.
//
// Summary of operation
// - Six filter banks; banks 4 and 5 have software-configured scale.
// - Setup and mode registers live in 16-byte pages via page select.
// - Bank 4/5 setup bits read/write, reset zero.
// - Setup bits 7 and 3 always read zero.
// - Bits 6:5 bank5 scale, 2:1 bank4 scale.
// - Bank 5 filters only while bit 4 set.
// - Bank 4 filters only while bit 0 set.
// - Mode bit 2n+1 high, 2n low; 1 list.
// - Mode register read/write, resets to zero.
`timescale 1ns/10ps
module cfb_config #(
  parameter int unsigned NUM_BANKS = cfb_pkg::NUM_BANKS
) (
  // Clock and reset.
  input  wire logic                 mclk_i,
  input  wire logic                 rstn_i,
  // Register port.
  input  wire logic [4:0]           addr_i,
  input  wire logic [7:0]           wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [7:0]           rdata_o,
  // Filter bank controls.
  output logic      [1:0]           bank5_scale_sel_o,
  output logic      [1:0]           bank4_scale_sel_o,
  output logic                      bank5_active_o,
  output logic                      bank4_active_o,
  output logic      [7:0]           bank_list_mode_o,
  output logic      [NUM_BANKS-1:0] bank_active_o,
  // Comparator hits in and gated acceptance out.
  input  wire logic [NUM_BANKS-1:0] bank_hit_i,
  output logic      [NUM_BANKS-1:0] bank_accept_o
);
  logic [2:0] page_sel;
  logic [7:0] filter_bank45_setup;
  logic [7:0] filter_bank0_3_mode;
  logic [7:0] rdata;
  logic [2:0] next_page_sel;
  logic [7:0] next_bank45;
  logic [7:0] next_mode;
  logic [7:0] next_rdata;
  logic       sel_bank45;
  logic       sel_mode;

  // Paged registers only decode while the filter page is selected; the page
  // select itself sits in the common top byte so it is always reachable.
  assign sel_bank45 = (addr_i == cfb_pkg::BANK45_ADDR) &&
                      (page_sel == cfb_pkg::FILTER_PAGE);
  assign sel_mode   = (addr_i == cfb_pkg::MODE03_ADDR) &&
                      (page_sel == cfb_pkg::FILTER_PAGE);

  // Next-state for the registers and the registered read data.
  always_comb begin
    next_page_sel = page_sel;
    next_bank45   = filter_bank45_setup;
    next_mode     = filter_bank0_3_mode;
    next_rdata    = 8'h00;
    if (wr_i) begin
      if (addr_i == cfb_pkg::PAGE_SEL_ADDR) begin
        next_page_sel = wdata_i[2:0];
      end
      if (sel_bank45) begin
        next_bank45 = wdata_i & cfb_pkg::BANK45_WMASK;
      end
      if (sel_mode) begin
        next_mode = wdata_i;
      end
    end
    if (rd_i) begin
      if (addr_i == cfb_pkg::PAGE_SEL_ADDR) begin
        next_rdata = {5'h00, page_sel};
      end else if (sel_bank45) begin
        next_rdata = filter_bank45_setup & cfb_pkg::BANK45_WMASK;
      end else if (sel_mode) begin
        next_rdata = filter_bank0_3_mode;
      end
    end
  end

  // Register stage; all state clears to zero on reset.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      page_sel            <= cfb_pkg::PAGE_SEL_RESET;
      filter_bank45_setup <= cfb_pkg::BANK45_RESET;
      filter_bank0_3_mode <= cfb_pkg::MODE03_RESET;
      rdata               <= 8'h00;
    end else begin
      page_sel            <= next_page_sel;
      filter_bank45_setup <= next_bank45;
      filter_bank0_3_mode <= next_mode;
      rdata               <= next_rdata;
    end
  end

  assign rdata_o = rdata;

  // Field outputs decoded straight from the stored register bits.
  assign bank5_scale_sel_o =
    filter_bank45_setup[cfb_pkg::B5_SCALE_HI:cfb_pkg::B5_SCALE_LO];
  assign bank4_scale_sel_o =
    filter_bank45_setup[cfb_pkg::B4_SCALE_HI:cfb_pkg::B4_SCALE_LO];
  assign bank5_active_o    = filter_bank45_setup[cfb_pkg::B5_ACTIVE_BIT];
  assign bank4_active_o    = filter_bank45_setup[cfb_pkg::B4_ACTIVE_BIT];
  // Bit 2n+1 is bank n high half, bit 2n its low half.
  assign bank_list_mode_o  = filter_bank0_3_mode;

  // Banks 0-3 carry no activate bit here, so they are always enabled.
  // Banks 4 and 5 follow their activate bits.
  always_comb begin
    bank_active_o    = '1;
    bank_active_o[4] = bank4_active_o;
    bank_active_o[5] = bank5_active_o;
  end

  // Gate comparator hits so an inactive bank cannot accept a frame.
  cfb_bank_gate #(
    .NB (NUM_BANKS)
  ) u_gate (
    .active_i (bank_active_o),
    .hit_i    (bank_hit_i),
    .accept_o (bank_accept_o)
  );

  // Software is trusted to clear an activate bit before editing bank values;
  // this block has no value registers, so it cannot police that ordering.
  // The outputs only reflect the setting, which the value store can rely on.

  // Reserved bits are cleared on every store, so no write can ever set them.
  a_reserved_zero: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    filter_bank45_setup[7] == 1'b0 && filter_bank45_setup[3] == 1'b0)
    else $error("reserved setup bits set");

  a_setup_write: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    wr_i && sel_bank45 |=> filter_bank45_setup == ($past(wdata_i) & 8'h77))
    else $error("setup write not stored");

  a_mode_write: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    wr_i && sel_mode |=> filter_bank0_3_mode == $past(wdata_i))
    else $error("mode write not stored");

  // Registers hold their value between writes that address them.
  a_setup_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !(wr_i && sel_bank45) |=> $stable(filter_bank45_setup))
    else $error("setup changed without write");

  a_mode_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !(wr_i && sel_mode) |=> $stable(filter_bank0_3_mode))
    else $error("mode changed without write");

  // Both registers come out of reset cleared.
  a_reset_clear: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(rstn_i) |-> filter_bank45_setup == 8'h00 && filter_bank0_3_mode == 8'h00)
    else $error("registers not cleared by reset");

  // Read data stands for one cycle after the strobe and is zero otherwise.
  a_read_setup: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    rd_i && sel_bank45 |=> rdata_o == $past(filter_bank45_setup))
    else $error("setup read wrong");

  a_read_mode: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    rd_i && sel_mode |=> rdata_o == $past(filter_bank0_3_mode))
    else $error("mode read wrong");

  a_rdata_idle: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data lingered");

  a_unmapped_read: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    rd_i && addr_i != 5'h0F && !sel_bank45 && !sel_mode |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");

  // The page select sits outside the window and is always reachable.
  a_page_write: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    wr_i && addr_i == 5'h0F |=> page_sel == $past(wdata_i[2:0]))
    else $error("page select write lost");

  a_page_read: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    rd_i && addr_i == 5'h0F |=> rdata_o == {5'h00, $past(page_sel)})
    else $error("page select read wrong");

  a_page_gate: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    wr_i && addr_i == 5'h10 && page_sel != 3'h6 |=> $stable(filter_bank45_setup))
    else $error("write leaked past page");

  a_mode_gate: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    wr_i && addr_i == 5'h11 && page_sel != 3'h6 |=> $stable(filter_bank0_3_mode))
    else $error("mode write leaked past page");

  // Field outputs must follow the written bits at their documented places.
  a_scale_fields: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    wr_i && sel_bank45 |=> bank5_scale_sel_o == $past(wdata_i[6:5]) &&
                           bank4_scale_sel_o == $past(wdata_i[2:1]))
    else $error("scale field misplaced");

  a_b5_activate: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    wr_i && sel_bank45 |=> bank5_active_o == $past(wdata_i[4]))
    else $error("bank5 activate bit misplaced");

  a_b4_activate: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    wr_i && sel_bank45 |=> bank4_active_o == $past(wdata_i[0]))
    else $error("bank4 activate bit misplaced");

  a_list_out: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    wr_i && sel_mode |=> bank_list_mode_o == $past(wdata_i))
    else $error("list mode output wrong");

  // Acceptance gating: inactive banks are silent, active banks pass hits.
  a_low_banks_on: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    bank_active_o[3:0] == 4'hF)
    else $error("low bank not enabled");

  a_b5_inactive: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !filter_bank45_setup[4] |-> !bank_accept_o[5])
    else $error("bank5 accepted inactive");

  a_b4_inactive: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !filter_bank45_setup[0] |-> !bank_accept_o[4])
    else $error("bank4 accepted inactive");

  a_b5_pass: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    bank5_active_o && bank_hit_i[5] |-> bank_accept_o[5])
    else $error("bank5 hit dropped");

  a_b4_pass: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    bank4_active_o && bank_hit_i[4] |-> bank_accept_o[4])
    else $error("bank4 hit dropped");

  a_accept_hit: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !(|(bank_accept_o & ~bank_hit_i)))
    else $error("accept without hit");
endmodule

// ### verif/cfb_hit_model.sv
// Far-side stand-in: comparator hits as a received frame would raise them.
// Assumes the bench names the banks that the current frame matches.
`timescale 1ns/10ps
module cfb_hit_model (
  // Clock.
  input  wire logic       mclk_i,
  // Banks matched by the frame, and the registered hits.
  input  wire logic [5:0] match_i,
  output logic      [5:0] bank_hit_o
);
  // Hits are registered, as a comparator on the same clock would deliver them.
  always_ff @(posedge mclk_i) begin
    bank_hit_o <= match_i;
  end
endmodule

// ### verif/cfb_config_tb.sv
// Bench for the filter configuration block: register port, field outputs, gated hits.
// Assumes the package constants and the comparator stand-in for the hit inputs.
`timescale 1ns/10ps
module cfb_config_tb;
  logic       mclk_i  = 1'b0;
  logic       rstn_i  = 1'b0;
  logic [4:0] addr_i  = 5'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i    = 1'b0;
  logic       rd_i    = 1'b0;
  logic [7:0] rdata_o, lmode, wd;
  logic [1:0] b5s, b4s;
  logic       b5a, b4a;
  logic [5:0] act, hit, acc;
  logic [5:0] match   = 6'h00;
  int         n_fail  = 0;
  int         check_count = 0;
  // Half period of 2 ns gives the 250 MHz clock.
  always #2 mclk_i = ~mclk_i;
  cfb_config dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bank5_scale_sel_o(b5s),
    .bank4_scale_sel_o(b4s), .bank5_active_o(b5a), .bank4_active_o(b4a),
    .bank_list_mode_o(lmode), .bank_active_o(act), .bank_hit_i(hit), .bank_accept_o(acc));
  cfb_hit_model hit_u (.mclk_i(mclk_i), .match_i(match), .bank_hit_o(hit));
  // One comparison; a mismatch is reported at once.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Single-cycle write strobe.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // Read, check the data cycle, then check that the data does not linger.
  task automatic rdc(input logic [4:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk(what, exp, rdata_o);
    @(posedge mclk_i);
    #1 chk("rdata idle", 8'h00, rdata_o);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence; the wrong-page write first proves the page gate holds.
  initial begin
    repeat (5) @(posedge mclk_i);
    rstn_i <= 1'b1;
    #1 chk("active at reset", 8'h0F, {b5a, b4a, act});
    rdc(cfb_pkg::PAGE_SEL_ADDR, 8'h00, "page select");
    wr(cfb_pkg::BANK45_ADDR, 8'hFF);
    wr(cfb_pkg::PAGE_SEL_ADDR, {5'h00, cfb_pkg::FILTER_PAGE});
    rdc(cfb_pkg::PAGE_SEL_ADDR, {5'h00, cfb_pkg::FILTER_PAGE}, "page select");
    rdc(cfb_pkg::BANK45_ADDR, 8'h00, "setup");
    rdc(cfb_pkg::MODE03_ADDR, 8'h00, "mode");
    rdc(5'h12, 8'h00, "unmapped");
    // Walk each bit alone, then all bits, set in setup and clear in mode. Each step
    // first idles banks 4 and 5 and only then changes what the comparator
    // matches, as software must before it edits a bank's values.
    for (int i = 0; i < 9; i++) begin
      wd = (i == 8) ? 8'hFF : (8'h01 << i);
      wr(cfb_pkg::BANK45_ADDR, 8'h00);
      match <= wd[5:0] ^ 6'h2A;
      repeat (2) @(posedge mclk_i);
      #1 chk("accept idle", {4'h0, match[3:0]}, {2'b00, acc});
      wr(cfb_pkg::BANK45_ADDR, wd);
      wr(cfb_pkg::MODE03_ADDR, ~wd);
      rdc(cfb_pkg::BANK45_ADDR, wd & 8'h77, "setup");
      rdc(cfb_pkg::MODE03_ADDR, ~wd, "mode");
      chk("scale", {2'b00, wd[6:5], 2'b00, wd[2:1]}, {2'b00, b5s, 2'b00, b4s});
      chk("mode out", ~wd, lmode);
      chk("active", {wd[4], wd[0], wd[4], wd[0], 4'hF}, {b5a, b4a, act});
      chk("accept", {2'b00, match & {wd[4], wd[0], 4'hF}}, {2'b00, acc});
    end
    // A reset in mid-run must clear what software has set up.
    wr(cfb_pkg::MODE03_ADDR, 8'hA5);
    @(posedge mclk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    #1 chk("active after reset", 8'h0F, {b5a, b4a, act});
    rdc(cfb_pkg::PAGE_SEL_ADDR, 8'h00, "page after reset");
    wr(cfb_pkg::PAGE_SEL_ADDR, {5'h00, cfb_pkg::FILTER_PAGE});
    rdc(cfb_pkg::BANK45_ADDR, cfb_pkg::BANK45_RESET, "setup after reset");
    rdc(cfb_pkg::MODE03_ADDR, cfb_pkg::MODE03_RESET, "mode after reset");
    close_out();
  end
  // Watchdog: the sequence needs about 170 cycles, so 5000 cycles is ample.
  initial begin
    #20000;
    n_fail++;
    close_out();
  end
endmodule
